// ### hw/blt_pkg.sv
// Shared constants, types and the parity function of both bus agents.
// Assumes a single synchronous bus clock shared by every agent.
package blt_pkg;
    localparam int unsigned AD_W        = 64;
    localparam int unsigned CBE_W       = 8;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned FIFO_DEPTH  = 32;
    localparam int unsigned FIRST_LIMIT = 16;
    localparam int unsigned NEXT_LIMIT  = 8;
    localparam int unsigned IRDY_LIMIT  = 8;
    localparam int unsigned STOP_MARGIN = 2;
    localparam int unsigned DEVSEL_WAIT = 5;

    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] BE_ALL     = 4'h0;
    localparam logic [3:0] BE_NONE    = 4'hF;
    localparam logic [1:0] CFG_TYPE0  = 2'h0;

    localparam logic [1:0] RESP_OK    = 2'h0;
    localparam logic [1:0] RESP_STOP  = 2'h1;
    localparam logic [1:0] RESP_ABORT = 2'h2;

    typedef enum logic [1:0] {TGT_IDLE, TGT_BUSY, TGT_DATA, TGT_TURN} blt_tgt_state_t;
    typedef enum logic [1:0] {MST_IDLE, MST_ADDR, MST_DATA, MST_END} blt_mst_state_t;

    // ----------------------------------------------------------------
    // Parity
    // ----------------------------------------------------------------
    // Even parity over one data half and its byte enables; the same for every command.
    function automatic logic blt_parity(input logic [31:0] d, input logic [3:0] c);
        return ^{d, c}; // RULE8 RULE9 RULE10
    endfunction : blt_parity
endpackage : blt_pkg

// ### hw/blt_bus_if.sv
// Shared bus between one master end and one target end.
// Assumes undriven lines float high, as with the central pull-ups.
`timescale 1ns/1ps
interface blt_bus_if;
    logic [63:0] m_ad_o;
    logic        m_ad_oe_n;
    logic [63:0] t_ad_o;
    logic        t_ad_oe_n;
    logic [7:0]  m_cbe_o;
    logic        m_cbe_oe_n;
    logic        m_frame_o;
    logic        m_irdy_o;
    logic        m_ctl_oe_n;
    logic        m_idsel_o;
    logic        t_trdy_o;
    logic        t_stop_o;
    logic        t_devsel_o;
    logic        t_ctl_oe_n;
    logic        m_par_o;
    logic        m_par64_o;
    logic        m_par_oe_n;
    logic        t_par_o;
    logic        t_par64_o;
    logic        t_par_oe_n;

    logic [63:0] ad;
    logic [7:0]  cbe_n;
    logic        frame_n;
    logic        irdy_n;
    logic        trdy_n;
    logic        stop_n;
    logic        devsel_n;
    logic        idsel;
    logic        par;
    logic        par64;

    assign ad       = !m_ad_oe_n ? m_ad_o : (!t_ad_oe_n ? t_ad_o : '1);
    assign cbe_n    = !m_cbe_oe_n ? m_cbe_o : '1;
    assign frame_n  = !m_ctl_oe_n ? m_frame_o : 1'b1;
    assign irdy_n   = !m_ctl_oe_n ? m_irdy_o : 1'b1;
    assign trdy_n   = !t_ctl_oe_n ? t_trdy_o : 1'b1;
    assign stop_n   = !t_ctl_oe_n ? t_stop_o : 1'b1;
    assign devsel_n = !t_ctl_oe_n ? t_devsel_o : 1'b1;
    assign idsel    = m_idsel_o;
    assign par      = !m_par_oe_n ? m_par_o : (!t_par_oe_n ? t_par_o : 1'b1);
    assign par64    = !m_par_oe_n ? m_par64_o : (!t_par_oe_n ? t_par64_o : 1'b1);

    modport master (
        output m_ad_o, m_ad_oe_n, m_cbe_o, m_cbe_oe_n, m_frame_o, m_irdy_o,
        output m_ctl_oe_n, m_idsel_o, m_par_o, m_par64_o, m_par_oe_n,
        input  ad, cbe_n, frame_n, irdy_n, trdy_n, stop_n, devsel_n, par, par64
    );
    modport target (
        output t_ad_o, t_ad_oe_n, t_trdy_o, t_stop_o, t_devsel_o, t_ctl_oe_n,
        output t_par_o, t_par64_o, t_par_oe_n,
        input  ad, cbe_n, frame_n, irdy_n, trdy_n, stop_n, devsel_n, idsel, par, par64
    );
endinterface : blt_bus_if

// ### hw/blt_target.sv
// Target end of the bus: decode, device select, latency control, parity.
// Write data is queued in a FIFO toward the user; read data comes from the user.
// Assumes the master asserts its ready within the bus limit in every data phase.
//
// Functional notes
// RULE1: First data phase done within 16 clocks.
// RULE2: Later data phases done within eight clocks.
// RULE3: Master asserts its ready within eight clocks.
// RULE4: Full address decode before any target response.
// RULE5: Device select asserted before ready or stop.
// RULE6: Device select held until last phase completes.
// RULE7: Type 0 configuration needs select and 00.
// RULE8: Parity computed alike for every transaction.
// RULE9: Even ones count over each half.
// RULE10: Parity generation always present, never disabled.
// RULE11: Only master reports parity errors otherwise.
// RULE12: Phase completes on ready with ready/stop.
// RULE13: Device select asserted marks the target.
// RULE14: Latency counter forces stop before limit.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Write data FIFO
// ----------------------------------------------------------------
module blt_fifo #(
    parameter int unsigned WIDTH = 64,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("FIFO depth must be a power of two of at least two.");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } blt_fifo_t;

    blt_fifo_t q;
    blt_fifo_t d;
    logic      push;
    logic      pop;

    assign in_ready  = (q.cnt != DEPTH[AW:0]);
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : blt_fifo

// ----------------------------------------------------------------
// Target end
// ----------------------------------------------------------------
module blt_target #(
    parameter logic [31:0] BASE_ADDR = 32'h1000_0000,
    parameter int unsigned WIN_BITS  = 12,
    parameter int unsigned DEPTH     = blt_pkg::FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    blt_bus_if.target        bus,
    output logic             wr_valid,
    input  wire logic        wr_ready,
    output logic [63:0]      wr_data,
    input  wire logic        rd_valid,
    input  wire logic [63:0] rd_data,
    output logic             rd_take
);
    if (WIN_BITS < 2 || WIN_BITS > 31) begin : g_chk
        $error("Window size must be between 2 and 31 address bits.");
    end

    typedef struct packed {
        blt_pkg::blt_tgt_state_t   st;
        logic                      frame_n_prev;
        logic                      is_write;
        logic                      first;
        logic [blt_pkg::CNT_W-1:0] cnt;
        logic                      devsel_n;
        logic                      trdy_n;
        logic                      stop_n;
        logic                      ctl_oe_n;
        logic [63:0]               ad;
        logic                      ad_oe_n;
        logic                      par;
        logic                      par64;
        logic                      par_oe_n;
        logic                      rd_take;
    } blt_tgt_t;

    localparam blt_tgt_t RESET = '{
        st: blt_pkg::TGT_IDLE, frame_n_prev: 1'b1, is_write: 1'b0, first: 1'b0,
        cnt: '0, devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1, ctl_oe_n: 1'b1,
        ad: '0, ad_oe_n: 1'b1, par: 1'b0, par64: 1'b0, par_oe_n: 1'b1, rd_take: 1'b0};

    blt_tgt_t                  q;
    blt_tgt_t                  d;
    logic                      push;
    logic                      fifo_ready;
    logic                      start;
    logic                      done;
    logic                      xfer;
    logic                      hit_mem;
    logic                      hit_cfg;
    logic [3:0]                cmd;
    logic [blt_pkg::CNT_W-1:0] lim;

    blt_fifo #(
        .WIDTH (64),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (bus.ad),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_data)
    );

    assign start = !bus.frame_n && q.frame_n_prev;
    assign done  = !bus.irdy_n && (!bus.trdy_n || !bus.stop_n); // RULE12
    assign xfer  = !bus.irdy_n && !bus.trdy_n;
    assign cmd   = bus.cbe_n[3:0];
    // Every address bit above the window is compared before a claim. RULE4
    assign hit_mem = (cmd == blt_pkg::CMD_MEM_RD || cmd == blt_pkg::CMD_MEM_WR)
                     && (bus.ad[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS]);
    assign hit_cfg = (cmd == blt_pkg::CMD_CFG_RD || cmd == blt_pkg::CMD_CFG_WR)
                     && bus.idsel && (bus.ad[1:0] == blt_pkg::CFG_TYPE0); // RULE7
    assign lim = q.first ? blt_pkg::CNT_W'(blt_pkg::FIRST_LIMIT - blt_pkg::STOP_MARGIN)
                         : blt_pkg::CNT_W'(blt_pkg::NEXT_LIMIT - blt_pkg::STOP_MARGIN);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d              = q;
        push           = 1'b0;
        d.rd_take      = 1'b0;
        d.frame_n_prev = bus.frame_n;
        // Parity follows the driven word by one clock. RULE8 RULE9 RULE10
        d.par_oe_n = q.ad_oe_n;
        d.par      = blt_pkg::blt_parity(bus.ad[31:0], bus.cbe_n[3:0]);
        d.par64    = blt_pkg::blt_parity(bus.ad[63:32], bus.cbe_n[7:4]);
        case (q.st)
            blt_pkg::TGT_IDLE: begin
                if (start && (hit_mem || hit_cfg)) begin
                    d.st       = blt_pkg::TGT_DATA;
                    d.devsel_n = 1'b0; // RULE13 RULE5
                    d.ctl_oe_n = 1'b0;
                    d.cnt      = blt_pkg::CNT_W'(1);
                    d.first    = 1'b1;
                    d.is_write = cmd[0];
                end else if (start) begin
                    d.st = blt_pkg::TGT_BUSY;
                end
            end
            blt_pkg::TGT_BUSY: begin
                if (bus.frame_n && bus.irdy_n) begin
                    d.st = blt_pkg::TGT_IDLE;
                end
            end
            blt_pkg::TGT_DATA: begin
                if (done) begin
                    d.cnt     = '0;
                    d.first   = 1'b0;
                    d.trdy_n  = 1'b1;
                    d.ad_oe_n = 1'b1;
                    push      = q.is_write && xfer;
                    // Select is only dropped once the final phase completes. RULE6
                    if (bus.frame_n) begin
                        d.st       = blt_pkg::TGT_TURN;
                        d.devsel_n = 1'b1;
                        d.stop_n   = 1'b1;
                    end
                end else begin
                    d.cnt = q.cnt + 1'b1;
                    // Ready or stop only rise while select is already low. RULE5
                    if (q.trdy_n && q.stop_n) begin
                        if (q.is_write ? fifo_ready : rd_valid) begin
                            d.trdy_n = 1'b0; // RULE1 RULE2
                            if (!q.is_write) begin
                                d.ad      = rd_data;
                                d.ad_oe_n = 1'b0;
                                d.rd_take = 1'b1;
                            end
                        end else if (d.cnt >= lim) begin
                            // The margin leaves room for the stop to complete. RULE14
                            d.stop_n = 1'b0; // RULE1 RULE2
                        end
                    end
                end
            end
            blt_pkg::TGT_TURN: begin
                d.ctl_oe_n = 1'b1;
                d.st       = blt_pkg::TGT_IDLE;
            end
            default: begin
                d = RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // A target raises no parity report of its own beyond the bus lines. RULE11
    assign bus.t_ad_o     = q.ad;
    assign bus.t_ad_oe_n  = q.ad_oe_n;
    assign bus.t_trdy_o   = q.trdy_n;
    assign bus.t_stop_o   = q.stop_n;
    assign bus.t_devsel_o = q.devsel_n;
    assign bus.t_ctl_oe_n = q.ctl_oe_n;
    assign bus.t_par_o    = q.par;
    assign bus.t_par64_o  = q.par64;
    assign bus.t_par_oe_n = q.par_oe_n;
    assign rd_take        = q.rd_take;
endmodule : blt_target

// ### hw/blt_master.sv
// Master end of the bus: single data phase reads and writes.
// Assumes it is the only master, so the bus is granted whenever idle.
`timescale 1ns/1ps
module blt_master (
    input  wire logic        clk,
    input  wire logic        rst_n,
    blt_bus_if.master        bus,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic        req_write,
    input  wire logic        req_cfg,
    input  wire logic [31:0] req_addr,
    input  wire logic [63:0] req_wdata,
    output logic             resp_valid,
    output logic [1:0]       resp_status,
    output logic [63:0]      resp_rdata,
    output logic             par_err
);
    typedef struct packed {
        blt_pkg::blt_mst_state_t   st;
        logic                      frame_n;
        logic                      irdy_n;
        logic                      ctl_oe_n;
        logic [63:0]               ad;
        logic                      ad_oe_n;
        logic [7:0]                cbe_n;
        logic                      cbe_oe_n;
        logic                      idsel;
        logic                      par;
        logic                      par64;
        logic                      par_oe_n;
        logic [blt_pkg::CNT_W-1:0] cnt;
        logic                      seen;
        logic                      write;
        logic [63:0]               wdata;
        logic                      req_ready;
        logic                      resp_valid;
        logic [1:0]                resp_status;
        logic [63:0]               resp_rdata;
        logic                      chk;
        logic [63:0]               chk_ad;
        logic [7:0]                chk_cbe;
        logic                      par_err;
    } blt_mst_t;

    localparam blt_mst_t RESET = '{
        st: blt_pkg::MST_IDLE, frame_n: 1'b1, irdy_n: 1'b1, ctl_oe_n: 1'b1,
        ad: '0, ad_oe_n: 1'b1, cbe_n: '1, cbe_oe_n: 1'b1, idsel: 1'b0,
        par: 1'b0, par64: 1'b0, par_oe_n: 1'b1, cnt: '0, seen: 1'b0,
        write: 1'b0, wdata: '0, req_ready: 1'b0, resp_valid: 1'b0,
        resp_status: blt_pkg::RESP_OK, resp_rdata: '0, chk: 1'b0,
        chk_ad: '0, chk_cbe: '1, par_err: 1'b0};

    blt_mst_t q;
    blt_mst_t d;
    logic     done;

    assign done = !bus.irdy_n && (!bus.trdy_n || !bus.stop_n); // RULE12

    always_comb begin
        d            = q;
        d.resp_valid = 1'b0;
        d.par_err    = 1'b0;
        d.chk        = 1'b0;
        d.par_oe_n   = q.ad_oe_n;
        d.par        = blt_pkg::blt_parity(bus.ad[31:0], bus.cbe_n[3:0]); // RULE8 RULE9
        d.par64      = blt_pkg::blt_parity(bus.ad[63:32], bus.cbe_n[7:4]); // RULE10
        // Read data parity is checked one clock later and reported here. RULE11
        if (q.chk) begin
            d.par_err = (blt_pkg::blt_parity(q.chk_ad[31:0], q.chk_cbe[3:0]) != bus.par)
                     || (blt_pkg::blt_parity(q.chk_ad[63:32], q.chk_cbe[7:4]) != bus.par64);
        end
        case (q.st)
            blt_pkg::MST_IDLE: begin
                d.req_ready = 1'b1;
                if (req_valid && q.req_ready && bus.frame_n && bus.irdy_n) begin
                    d.req_ready = 1'b0;
                    d.st        = blt_pkg::MST_ADDR;
                    d.frame_n   = 1'b0;
                    d.ctl_oe_n  = 1'b0;
                    d.ad        = {32'h0000_0000, req_addr};
                    d.ad_oe_n   = 1'b0;
                    d.cbe_oe_n  = 1'b0;
                    d.idsel     = req_cfg;
                    d.write     = req_write;
                    d.wdata     = req_wdata;
                    d.cbe_n     = {blt_pkg::BE_NONE, req_cfg
                        ? (req_write ? blt_pkg::CMD_CFG_WR : blt_pkg::CMD_CFG_RD)
                        : (req_write ? blt_pkg::CMD_MEM_WR : blt_pkg::CMD_MEM_RD)};
                end
            end
            blt_pkg::MST_ADDR: begin
                // Ready rises at once, well inside the limit. RULE3
                d.st      = blt_pkg::MST_DATA;
                d.frame_n = 1'b1;
                d.irdy_n  = 1'b0;
                d.idsel   = 1'b0;
                d.cbe_n   = {blt_pkg::BE_ALL, blt_pkg::BE_ALL};
                d.ad      = q.wdata;
                d.ad_oe_n = !q.write;
                d.cnt     = '0;
                d.seen    = 1'b0;
            end
            blt_pkg::MST_DATA: begin
                d.cnt  = q.cnt + 1'b1;
                d.seen = q.seen || !bus.devsel_n;
                if (done || (!d.seen && d.cnt >= blt_pkg::CNT_W'(blt_pkg::DEVSEL_WAIT))) begin
                    d.st          = blt_pkg::MST_END;
                    d.irdy_n      = 1'b1;
                    d.ad_oe_n     = 1'b1;
                    d.resp_valid  = 1'b1;
                    d.resp_rdata  = bus.ad;
                    d.resp_status = !done ? blt_pkg::RESP_ABORT
                                  : (!bus.trdy_n ? blt_pkg::RESP_OK : blt_pkg::RESP_STOP);
                    d.chk         = done && !q.write && !bus.trdy_n;
                    d.chk_ad      = bus.ad;
                    d.chk_cbe     = bus.cbe_n;
                end
            end
            blt_pkg::MST_END: begin
                d.ctl_oe_n  = 1'b1;
                d.cbe_oe_n  = 1'b1;
                d.st        = blt_pkg::MST_IDLE;
            end
            default: begin
                d = RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RESET;
        end else begin
            q <= d;
        end
    end

    assign bus.m_ad_o     = q.ad;
    assign bus.m_ad_oe_n  = q.ad_oe_n;
    assign bus.m_cbe_o    = q.cbe_n;
    assign bus.m_cbe_oe_n = q.cbe_oe_n;
    assign bus.m_frame_o  = q.frame_n;
    assign bus.m_irdy_o   = q.irdy_n;
    assign bus.m_ctl_oe_n = q.ctl_oe_n;
    assign bus.m_idsel_o  = q.idsel;
    assign bus.m_par_o    = q.par;
    assign bus.m_par64_o  = q.par64;
    assign bus.m_par_oe_n = q.par_oe_n;
    assign req_ready      = q.req_ready;
    assign resp_valid     = q.resp_valid;
    assign resp_status    = q.resp_status;
    assign resp_rdata     = q.resp_rdata;
    assign par_err        = q.par_err;
endmodule : blt_master

// ### verif/blt_props.sv
// Checker of the bus lines between the master end and the target end.
// Assumes it sees the resolved lines of the single interface in the bench.
`timescale 1ns/1ps
module blt_props #(
    parameter logic [31:0] BASE_ADDR = 32'h1000_0000,
    parameter int unsigned WIN_BITS  = 12
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [63:0] ad,
    input wire logic [7:0]  cbe_n,
    input wire logic        frame_n,
    input wire logic        irdy_n,
    input wire logic        trdy_n,
    input wire logic        stop_n,
    input wire logic        devsel_n,
    input wire logic        idsel,
    input wire logic        par,
    input wire logic        par64,
    input wire logic        m_par_oe_n,
    input wire logic        t_par_oe_n
);
    logic hit;
    logic done;
    logic mem_cmd;
    logic cfg_cmd;
    assign done    = !irdy_n && (!trdy_n || !stop_n);
    assign mem_cmd = cbe_n[3:0] == blt_pkg::CMD_MEM_RD || cbe_n[3:0] == blt_pkg::CMD_MEM_WR;
    assign cfg_cmd = cbe_n[3:0] == blt_pkg::CMD_CFG_RD || cbe_n[3:0] == blt_pkg::CMD_CFG_WR;
    assign hit     = (mem_cmd && ad[31:WIN_BITS] == BASE_ADDR[31:WIN_BITS])
                  || (cfg_cmd && idsel && ad[1:0] == blt_pkg::CFG_TYPE0);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence start_s; $fell(frame_n); endsequence
    sequence claim_s; start_s ##1 !devsel_n; endsequence
    first_phase_a: assert property (claim_s |-> ##[0:15] done)
        else $error("first data phase not done in time");
    master_ready_a: assert property (start_s |-> ##[1:8] !irdy_n)
        else $error("master ready late");
    hit_claim_a: assert property (start_s and hit |=> !devsel_n)
        else $error("decoded hit not claimed");
    miss_quiet_a: assert property (start_s and !hit |=> devsel_n [*4])
        else $error("miss was claimed");
    select_first_a: assert property ((!trdy_n || !stop_n) |-> !devsel_n)
        else $error("ready or stop without select");
    select_hold_a: assert property (!devsel_n && !(done && frame_n) |=> !devsel_n)
        else $error("select dropped early");
    end_release_a: assert property (done && frame_n |=> devsel_n && trdy_n && stop_n)
        else $error("target lines not released");
    // Parity lags its data by one clock, so it is judged on the previous lines.
    par_low_a: assert property (!(m_par_oe_n && t_par_oe_n) |->
        par == ^{$past(ad[31:0]), $past(cbe_n[3:0])}) else $error("low parity wrong");
    par_high_a: assert property (!(m_par_oe_n && t_par_oe_n) |->
        par64 == ^{$past(ad[63:32]), $past(cbe_n[7:4])}) else $error("high parity wrong");
endmodule : blt_props

// ### verif/testbench.sv
// Self-checking bench: the master end and the target end joined by one bus.
// Assumes the user sides of both ends are free for the bench to drive.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic        w;
        logic        c;
        logic [31:0] a;
        logic [63:0] d;
        logic        rv;
        logic [1:0]  st;
    } blt_row_t;
    logic        clk, rst_n, req_valid, req_ready, req_write, req_cfg, resp_valid;
    logic        par_err, wr_valid, wr_ready, rd_valid, rd_take;
    logic [1:0]  resp_status;
    logic [31:0] req_addr;
    logic [63:0] req_wdata, resp_rdata, wr_data, rd_data;
    int          n_mismatch, checks_done, n_cyc, n_take;
    logic [63:0] q[$];
    blt_row_t    rows[7];
    blt_bus_if bus ();
    blt_master u_blt_master (.clk(clk), .rst_n(rst_n), .bus(bus), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_cfg(req_cfg), .req_addr(req_addr),
        .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_status(resp_status),
        .resp_rdata(resp_rdata), .par_err(par_err));
    blt_target u_blt_target (.clk(clk), .rst_n(rst_n), .bus(bus), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_take(rd_take));
    blt_props u_blt_props (.clk(clk), .rst_n(rst_n), .ad(bus.ad), .cbe_n(bus.cbe_n),
        .frame_n(bus.frame_n), .irdy_n(bus.irdy_n), .trdy_n(bus.trdy_n), .stop_n(bus.stop_n),
        .devsel_n(bus.devsel_n), .idsel(bus.idsel), .par(bus.par), .par64(bus.par64),
        .m_par_oe_n(bus.m_par_oe_n), .t_par_oe_n(bus.t_par_oe_n));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk_w(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: word %h not %h", $time, got, exp);
        end
    endtask : chk_w
    task automatic chk_st(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: status %h not %h", $time, got, exp);
        end
    endtask : chk_st
    task automatic chk_b(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk_b
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    // The gap of three clocks keeps clear of the idle turn after each response.
    task automatic do_req(input blt_row_t r);
        int k;
        repeat (3) @(posedge clk);
        req_valid <= 1'b1;
        req_write <= r.w;
        req_cfg   <= r.c;
        req_addr  <= r.a;
        req_wdata <= r.d;
        rd_valid  <= r.rv;
        rd_data   <= r.d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (req_ready !== 1'b1 && k < 20);
        req_valid <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (resp_valid !== 1'b1 && k < 60);
        chk_b(resp_valid, 1'b1);
        rd_valid <= 1'b0;
    endtask : do_req
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_cyc <= n_cyc + 1;
        if (rd_take === 1'b1) n_take <= n_take + 1;
        if (rst_n) chk_b(par_err, 1'b0);
        if (n_cyc == 6000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        blt_row_t r;
        int i;
        {rst_n, req_valid, req_write, req_cfg, wr_ready, rd_valid} = '0;
        {req_addr, req_wdata, rd_data} = '0;
        {n_mismatch, checks_done, n_cyc, n_take} = '0;
        rows[0] = '{1'b1, 1'b0, 32'h1000_0010, 64'hA5A5_0000_1111_2222, 1'b0, blt_pkg::RESP_OK};
        rows[1] = '{1'b0, 1'b0, 32'h1000_0FF8, 64'h0123_4567_89AB_CDEF, 1'b1, blt_pkg::RESP_OK};
        rows[2] = '{1'b0, 1'b0, 32'h1000_0020, 64'h0, 1'b0, blt_pkg::RESP_STOP};
        rows[3] = '{1'b1, 1'b0, 32'h1000_1000, 64'h5A5A, 1'b0, blt_pkg::RESP_ABORT};
        rows[4] = '{1'b0, 1'b1, 32'h0000_0000, 64'hFEDC_BA98_7654_3210, 1'b1, blt_pkg::RESP_OK};
        rows[5] = '{1'b0, 1'b1, 32'h0000_0001, 64'h0, 1'b1, blt_pkg::RESP_ABORT};
        rows[6] = '{1'b1, 1'b1, 32'h0000_0004, 64'h8000_0000_0000_0001, 1'b0, blt_pkg::RESP_OK};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i++) begin
            do_req(rows[i]);
            chk_st(resp_status, rows[i].st);
            if (!rows[i].w && rows[i].st == blt_pkg::RESP_OK) chk_w(resp_rdata, rows[i].d);
            if (rows[i].w && rows[i].st == blt_pkg::RESP_OK) q.push_back(rows[i].d);
        end
        chk_b(n_take == 2, 1'b1);
        // Two words already sit in the buffer; fill it to 32, the next write is stopped.
        for (i = 0; i < 31; i++) begin
            r = '{1'b1, 1'b0, 32'h1000_0100, 64'(i), 1'b0, 2'h0};
            r.st = (i < 30) ? blt_pkg::RESP_OK : blt_pkg::RESP_STOP;
            do_req(r);
            chk_st(resp_status, r.st);
            if (i < 30) q.push_back(r.d);
        end
        for (i = 0; i < 200 && q.size() > 0; i++) begin
            @(posedge clk);
            if (wr_valid === 1'b1 && wr_ready === 1'b1) chk_w(wr_data, q.pop_front());
            wr_ready <= ~wr_ready;
        end
        #1;
        chk_b(wr_valid, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk_b(req_ready | resp_valid | wr_valid | !bus.devsel_n, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        do_req(rows[1]);
        chk_st(resp_status, blt_pkg::RESP_OK);
        chk_w(resp_rdata, rows[1].d);
        wrap_up();
    end
endmodule : testbench
